// [rtl/asram_pkg.sv]
// Operation
// - Write data stands stable the setup time before the ending rising edge.
// - Select falls early enough for its access delay to end in time.
// - Write enable stays low at least 200 ns basic, 250 ns power-down.
// - Select stays low before write enable rises for the write pulse minimum.
// - Write enable may fall once address is stable; address holds until rise.
// - Address may change right after write enable rises.
package asram_pkg;

	localparam int ADDR_W              = 12;
	localparam int CLK_PERIOD_NS       = 5;
	// Slowest grade figures, in ns
	localparam int ADDRESS_ACCESS_DELAY_NS = 450;
	localparam int READ_CYCLE_TIME_NS      = 450;
	localparam int WRITE_CYCLE_TIME_NS     = 450;
	localparam int WRITE_PULSE_WIDTH_NS    = 250;
	localparam int SELECT_TO_WRITE_END_NS  = 250;
	localparam int WRITE_DATA_SETUP_NS     = 200;
	localparam int WRITE_RECOVERY_TIME_NS  = 0;
	localparam int DESELECT_TO_OUTPUT_OFF_NS = 100;
	localparam int DESELECT_TO_STANDBY_DELAY_NS = 200;

	// Least times round up
	localparam int READ_CYC    = (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int ACCESS_CYC  = (ADDRESS_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int PULSE_CYC   = (WRITE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int WCYCLE_CYC  = (WRITE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int OFF_CYC     = (DESELECT_TO_OUTPUT_OFF_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CNT_W       = 8;

	localparam logic [CNT_W-1:0] CNT_ZERO   = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE    = 8'h01;
	localparam logic [CNT_W-1:0] ACCESS_CNT = CNT_W'(ACCESS_CYC);
	localparam logic [CNT_W-1:0] PULSE_CNT  = CNT_W'(PULSE_CYC);
	localparam logic [CNT_W-1:0] TAIL_CNT   = CNT_W'(WCYCLE_CYC - PULSE_CYC);
	localparam logic [CNT_W-1:0] OFF_CNT    = CNT_W'(OFF_CYC);

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic              wdata;
	} asram_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              select_n;
		logic              write_enable_n;
		logic              din;
	} asram_pins_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_READ,
		ST_WPULSE,
		ST_WTAIL,
		ST_OFF
	} asram_state_t;

endpackage : asram_pkg

// [rtl/asram_host.sv]
`timescale 1ns/100ps
module asram_host
	import asram_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// Request side
	input  wire asram_req_t  req,
	input  wire logic        req_valid,
	output      logic        req_ready,
	output      logic        rdata_q,
	output      logic        rdata_valid_q,
	output      logic        wdone_q,
	// Memory pins
	output      asram_pins_t pins_q,
	input  wire logic        dout
);

	asram_state_t     state_q;
	logic [CNT_W-1:0] cnt_q;

	assign req_ready = (state_q == ST_IDLE);

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q <= ST_IDLE;
			cnt_q   <= CNT_ZERO;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (req_valid) begin
						if (req.write) begin
							state_q <= ST_WPULSE;
							cnt_q   <= PULSE_CNT;
						end else begin
							state_q <= ST_READ;
							cnt_q   <= ACCESS_CNT;
						end
					end
				end
				ST_READ: begin
					if (cnt_q == CNT_ONE) begin
						state_q <= ST_OFF;
						cnt_q   <= OFF_CNT;
					end else begin
						cnt_q <= cnt_q - CNT_ONE;
					end
				end
				ST_WPULSE: begin
					if (cnt_q == CNT_ONE) begin
						state_q <= ST_WTAIL;
						cnt_q   <= TAIL_CNT;
					end else begin
						cnt_q <= cnt_q - CNT_ONE;
					end
				end
				ST_WTAIL: begin
					if (cnt_q <= CNT_ONE) begin
						state_q <= ST_OFF;
						cnt_q   <= OFF_CNT;
					end else begin
						cnt_q <= cnt_q - CNT_ONE;
					end
				end
				ST_OFF: begin
					if (cnt_q == CNT_ONE) begin
						state_q <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q - CNT_ONE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pins_q <= '{addr: '0, select_n: 1'b1, write_enable_n: 1'b1,
				din: 1'b0};
		end else if (state_q == ST_IDLE && req_valid) begin
			pins_q.addr     <= req.addr;
			pins_q.din      <= req.wdata;
			pins_q.select_n <= 1'b0;
			pins_q.write_enable_n <= ~req.write;
		end else if (state_q == ST_WPULSE && cnt_q == CNT_ONE) begin
			pins_q.write_enable_n <= 1'b1;
		end else if ((state_q == ST_READ && cnt_q == CNT_ONE) ||
			(state_q == ST_WTAIL && cnt_q <= CNT_ONE)) begin
			pins_q.select_n <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read capture and completion
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdata_q       <= 1'b0;
			rdata_valid_q <= 1'b0;
			wdone_q       <= 1'b0;
		end else begin
			rdata_valid_q <= 1'b0;
			wdone_q       <= 1'b0;
			if (state_q == ST_READ && cnt_q == CNT_ONE) begin
				rdata_q       <= dout;
				rdata_valid_q <= 1'b1;
			end
			if (state_q == ST_WPULSE && cnt_q == CNT_ONE) begin
				wdone_q <= 1'b1;
			end
		end
	end

endmodule : asram_host

// [testbench/asram_chk.sv]
`timescale 1ns/100ps
module asram_chk
	import asram_pkg::*;
(
	// Watched host ports
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        rdata_q,
	input wire logic        rdata_valid_q,
	input wire logic        wdone_q,
	input wire asram_pins_t pins_q,
	input wire logic        dout
);
	logic sn, wn;
	assign sn = pins_q.select_n;
	assign wn = pins_q.write_enable_n;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	property p_wsel; $fell(wn) |-> !sn; endproperty
	a_wsel: assert property (p_wsel) else $error("write while deselected");
	property p_wdat; !wn ##1 !wn |-> $stable(pins_q); endproperty
	a_wdat: assert property (p_wdat) else $error("pins moved in write");
	property p_pulse; $rose(wn) |-> $past(wn, 51) && !$past(wn, 50); endproperty
	a_pulse: assert property (p_pulse) else $error("bad write pulse");
	property p_csw; $rose(wn) |-> !sn && !$past(sn, 50) && wdone_q; endproperty
	a_csw: assert property (p_csw) else $error("select short in write");
	property p_rd; rdata_valid_q |-> $rose(sn) && !$past(sn, 90); endproperty
	a_rd: assert property (p_rd) else $error("read access too short");
	property p_rdat; rdata_valid_q |-> rdata_q == $past(dout); endproperty
	a_rdat: assert property (p_rdat) else $error("read bit not captured");
endmodule : asram_chk
bind asram_host asram_chk i_chk (.core_clk(core_clk), .reset(reset),
	.rdata_q(rdata_q), .rdata_valid_q(rdata_valid_q), .wdone_q(wdone_q),
	.pins_q(pins_q), .dout(dout));

// [testbench/asram_mem_model.sv]
`timescale 1ns/100ps
module asram_mem_model
	import asram_pkg::*;
(
	// Memory pins
	input  wire logic        core_clk,
	input  wire asram_pins_t pins,
	output      logic        dout
);
	logic              mem [4096] = '{default: 1'b0};
	logic [ADDR_W-1:0] a_q;
	logic              ov_q = 1'b0;
	logic              last_q = 1'b0;
	logic              d_q;
	logic              on;
	assign on = !pins.select_n && pins.write_enable_n;
	// Released line shows the inverse bit
	assign dout = on ? mem[pins.addr] : ~last_q;
	////////////////////////////////////////
	always @(posedge core_clk) begin
		if (ov_q && (pins.select_n || pins.write_enable_n)) mem[a_q] <= d_q;
		ov_q <= !pins.select_n && !pins.write_enable_n;
		a_q <= pins.addr;
		d_q <= pins.din;
		if (on) last_q <= mem[pins.addr];
	end
endmodule : asram_mem_model

// [testbench/testbench.sv]
`timescale 1ns/100ps
module testbench import asram_pkg::*;;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic        req_valid = 1'b0;
	asram_req_t  req = '0;
	logic        req_ready, rdata_q, rdata_valid_q, wdone_q, dout;
	asram_pins_t pins_q;
	int          fails = 0, checks_done = 0, cyc = 0, seed = 76227;
	bit          exp_mem [4096];
	logic [13:0] tbl [7] = '{14'h3fff, 14'h2000, 14'h1ffe, 14'h0000,
		14'h2001, 14'h0000, 14'h0000};
	always #2.5 core_clk = ~core_clk;
	asram_host i_dut (.core_clk(core_clk), .reset(reset), .req(req),
		.req_valid(req_valid), .req_ready(req_ready), .rdata_q(rdata_q),
		.rdata_valid_q(rdata_valid_q), .wdone_q(wdone_q), .pins_q(pins_q),
		.dout(dout));
	asram_mem_model i_mem (.core_clk(core_clk), .pins(pins_q), .dout(dout));
	////////////////////////////////////////
	function automatic int lat(input logic w);
		return w ? PULSE_CYC + 1 : ACCESS_CYC + 1;
	endfunction : lat
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	task automatic do_op(input logic w, input logic [ADDR_W-1:0] a,
		input logic d);
		int n;
		n = 0;
		while (req_ready !== 1'b1) @(negedge core_clk);
		@(posedge core_clk);
		req <= '{write: w, addr: a, wdata: d};
		req_valid <= 1'b1;
		@(posedge core_clk);
		req_valid <= 1'b0;
		while (rdata_valid_q !== 1'b1 && wdone_q !== 1'b1 && n < 200) begin
			@(negedge core_clk);
			n++;
		end
		chk(32'(n), 32'(lat(w)));
		chk({31'h0, req_ready}, 32'h0);
		if (w) exp_mem[a] = d;
		else chk({31'h0, rdata_q}, {31'h0, exp_mem[a]});
	endtask : do_op
	initial begin
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		foreach (tbl[i]) do_op(tbl[i][13], tbl[i][12:1], tbl[i][0]);
		$display("test corner done");
		repeat (30) do_op(1'($random(seed)), {8'h00, 4'($random(seed))},
			1'($random(seed)));
		$display("test random done");
		print_verdict();
	end
	always @(posedge core_clk) begin
		if (++cyc == 8000) begin
			fails++;
			print_verdict();
		end
	end
endmodule : testbench
